// ---- rtl/dcc_consts.vh ----
// Constants shared by the dual comparator control block
`ifndef DCC_CONSTS_VH
`define DCC_CONSTS_VH

// ----------------------------------------------------------------
// Register indices and byte addresses
// ----------------------------------------------------------------
`define DCC_IDX_CTL        12'h01F
`define DCC_IDX_FLAG       12'h00C
`define DCC_IDX_DIR        12'h085
`define DCC_IDX_STAT       12'h020
`define DCC_ADDR_CTL       {`DCC_IDX_CTL, 2'h0}
`define DCC_ADDR_FLAG      {`DCC_IDX_FLAG, 2'h0}
`define DCC_ADDR_DIR       {`DCC_IDX_DIR, 2'h0}
`define DCC_ADDR_STAT      {`DCC_IDX_STAT, 2'h0}
`define DCC_ADDR_W         14

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define DCC_CTL_RES2_BIT   7
`define DCC_CTL_RES1_BIT   6
`define DCC_CTL_CIS_BIT    3
`define DCC_CTL_MODE_MSB   2
`define DCC_CTL_MODE_LSB   0
`define DCC_FLAG_BIT       6
`define DCC_DIR_MSB        4
`define DCC_STAT_SETTLE    0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define DCC_MODE_RST       3'h0
`define DCC_CIS_RST        1'h0
`define DCC_DIR_RST        5'h1F
`define DCC_CFG_W          16

// ----------------------------------------------------------------
// Comparator modes and input pin selects
// ----------------------------------------------------------------
`define DCC_MODE_RESET     3'h0
`define DCC_MODE_3IN_MUX   3'h1
`define DCC_MODE_4IN_MUX   3'h2
`define DCC_MODE_COMMON    3'h3
`define DCC_MODE_INDEP     3'h4
`define DCC_MODE_SINGLE    3'h5
`define DCC_MODE_COMMON_O  3'h6
`define DCC_MODE_OFF       3'h7
`define DCC_PIN_RA0        2'h0
`define DCC_PIN_RA1        2'h1
`define DCC_PIN_RA2        2'h2
`define DCC_PIN_RA3        2'h3

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define DCC_CLK_NS         10
`define DCC_SETTLE_NS      10000
`define DCC_SETTLE_W       16

// ----------------------------------------------------------------
// Bus encodings
// ----------------------------------------------------------------
`define DCC_HTRANS_NONSEQ  2'h2
`define DCC_HRESP_OKAY     1'h0

`endif

// ---- rtl/dcc_sync.v ----
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps

module dcc_sync #(
  parameter WIDTH = 2
) (
  // Clock and reset
  input  wire             clk,
  input  wire             nrst,
  input  wire             ce,
  // Data
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out_ff
);

  reg [WIDTH-1:0] s1_ff;
  reg [WIDTH-1:0] s2_ff;
  reg [WIDTH-1:0] s3_ff;
  wire [WIDTH-1:0] nxt_sync_out;

  // ----------------------------------------------------------------
  // Stages
  // ----------------------------------------------------------------
  // First stage feeds only the second, never any logic
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      assign nxt_sync_out[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : sync_out_ff[i];
    end
  endgenerate

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_ff       <= {WIDTH{1'b0}};
      s2_ff       <= {WIDTH{1'b0}};
      s3_ff       <= {WIDTH{1'b0}};
      sync_out_ff <= {WIDTH{1'b0}};
    end else if (ce) begin
      s1_ff       <= async_in;
      s2_ff       <= s1_ff;
      s3_ff       <= s2_ff;
      sync_out_ff <= nxt_sync_out;
    end
  end

endmodule

// ---- rtl/dcc_top.v ----
// Dual comparator control and status logic with AHB-Lite register access
//
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "dcc_consts.vh"

// Notes on behaviour
// - Control bit 7 reads comparator 2 result, 1 when plus input exceeds minus.
// - Control bit 6 reads comparator 1 result, 1 when plus input exceeds minus.
// - Control bits 5 and 4 ignore writes and read zero.
// - Bits 2 to 0 pick one of eight modes setting both multiplexers.
// - Bit 3 steers inverting-input multiplexers in modes that use it.
// - Comparator inputs come from four port-A pins or the internal reference.
// - Port-A direction bits keep controlling pin direction in every mode.
// - Modes offer both a shared reference and separate references.
// - Reset clears control register, giving mode 000, analog pins, comparators off.
// - Change flag sets on result mismatch, and also on a written one.
// - Any control read or write ends mismatch; access before clearing the flag.
// - Mode 110 routes raw comparator results to RA3 and RA4, direction gated.
module dcc_top #(
  parameter SETTLE_NS = `DCC_SETTLE_NS,
  parameter CLK_NS    = `DCC_CLK_NS
) (
  // Clock, reset, enable
  input  wire        clk,
  input  wire        nrst,
  input  wire        ce,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire        hready,
  input  wire [31:0] hwdata,
  output reg  [31:0] hrdata_ff,
  output reg         hreadyout_ff,
  output reg         hresp_ff,
  // Asynchronous comparator results
  input  wire        cmp1_raw,
  input  wire        cmp2_raw,
  // Analog multiplexer controls
  output reg  [1:0]  cmp_power_en_ff,
  output reg         cmp_pos_vref_ff,
  output reg  [1:0]  cmp1_pos_sel_ff,
  output reg  [1:0]  cmp1_neg_sel_ff,
  output reg  [1:0]  cmp2_pos_sel_ff,
  output reg  [1:0]  cmp2_neg_sel_ff,
  output reg  [3:0]  pa_analog_en_ff,
  // Pin output path
  output reg         ra3_ra4_cmp_route_ff,
  output reg  [4:0]  pa_oe_ff,
  // Status
  output reg         comparator_change_flag_ff,
  output reg         result_settling_ff
);

  // ----------------------------------------------------------------
  // Settling count
  // ----------------------------------------------------------------
  // Rounded up: a coarse clock must never shorten the window
  localparam integer SETTLE_RAW = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam integer SETTLE_CYC = (SETTLE_RAW < 1) ? 1 : SETTLE_RAW;
  localparam [`DCC_SETTLE_W-1:0] SETTLE_LOAD = SETTLE_CYC[`DCC_SETTLE_W-1:0];

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  // Returns {power, vref_pos, c1pos, c1neg, c2pos, c2neg, analog, route}
  // Unused selects park on RA0
  function [`DCC_CFG_W-1:0] mode_cfg;
    input [2:0] mode;
    input       input_switch_select;
    begin
      case (mode)
        `DCC_MODE_3IN_MUX: begin
          mode_cfg = {2'h3, 1'b0, `DCC_PIN_RA2, (input_switch_select ? `DCC_PIN_RA3 : `DCC_PIN_RA0),
                      `DCC_PIN_RA2, `DCC_PIN_RA1, 4'hF, 1'b0};
        end
        `DCC_MODE_4IN_MUX: begin
          mode_cfg = {2'h3, 1'b1, `DCC_PIN_RA0, (input_switch_select ? `DCC_PIN_RA3 : `DCC_PIN_RA0),
                      `DCC_PIN_RA0, (input_switch_select ? `DCC_PIN_RA2 : `DCC_PIN_RA1),
                      4'hF, 1'b0};
        end
        `DCC_MODE_COMMON: begin
          mode_cfg = {2'h3, 1'b0, `DCC_PIN_RA2, `DCC_PIN_RA0,
                      `DCC_PIN_RA2, `DCC_PIN_RA1, 4'h7, 1'b0};
        end
        `DCC_MODE_INDEP: begin
          mode_cfg = {2'h3, 1'b0, `DCC_PIN_RA3, `DCC_PIN_RA0,
                      `DCC_PIN_RA2, `DCC_PIN_RA1, 4'hF, 1'b0};
        end
        `DCC_MODE_SINGLE: begin
          mode_cfg = {2'h2, 1'b0, `DCC_PIN_RA0, `DCC_PIN_RA0,
                      `DCC_PIN_RA2, `DCC_PIN_RA1, 4'h6, 1'b0};
        end
        `DCC_MODE_COMMON_O: begin
          mode_cfg = {2'h3, 1'b0, `DCC_PIN_RA2, `DCC_PIN_RA0,
                      `DCC_PIN_RA2, `DCC_PIN_RA1, 4'h7, 1'b1};
        end
        `DCC_MODE_OFF: begin
          mode_cfg = {2'h0, 1'b0, `DCC_PIN_RA0, `DCC_PIN_RA0,
                      `DCC_PIN_RA0, `DCC_PIN_RA0, 4'h0, 1'b0};
        end
        default: begin
          // Reset mode: every pin analog, both comparators off
          mode_cfg = {2'h0, 1'b0, `DCC_PIN_RA0, `DCC_PIN_RA0,
                      `DCC_PIN_RA0, `DCC_PIN_RA0, 4'hF, 1'b0};
        end
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg  [2:0]                mode_ff;
  reg                       cis_ff;
  reg  [`DCC_DIR_MSB:0]     dir_ff;
  // Results as seen at the last control access
  reg  [1:0]                latched_res_ff;
  reg  [`DCC_SETTLE_W-1:0]  settle_cnt_ff;
  reg                       wr_pend_ff;
  reg                       rd_pend_ff;
  reg  [`DCC_ADDR_W-1:0]    addr_ff;
  wire [1:0]                res_sync;
  wire                      res1;
  wire                      res2;
  wire                      ap_take;
  wire                      ctl_wr;
  wire                      ctl_rd;
  wire                      flag_wr;
  wire                      mismatch;
  reg  [31:0]               rdata;
  reg  [2:0]                nxt_mode;
  reg                       nxt_cis;
  reg                       nxt_flag;
  reg  [`DCC_SETTLE_W-1:0]  nxt_settle_cnt;
  reg  [`DCC_CFG_W-1:0]     nxt_cfg;

  // ----------------------------------------------------------------
  // Comparator result synchroniser
  // ----------------------------------------------------------------
  // Pad mux takes the raw result; status and flag use this copy
  dcc_sync #(
    .WIDTH       (2)
  ) u_sync (
    .clk         (clk),
    .nrst        (nrst),
    .ce          (ce),
    .async_in    ({cmp2_raw, cmp1_raw}),
    .sync_out_ff (res_sync)
  );

  assign res1 = res_sync[0];
  assign res2 = res_sync[1];

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Reads cost one wait state so a write just before is always visible
  // Size ignored: every register is one aligned word
  assign ap_take = hsel & hready & (htrans == `DCC_HTRANS_NONSEQ);
  assign ctl_wr  = wr_pend_ff & (addr_ff == `DCC_ADDR_CTL);
  assign flag_wr = wr_pend_ff & (addr_ff == `DCC_ADDR_FLAG);
  assign ctl_rd  = rd_pend_ff & (addr_ff == `DCC_ADDR_CTL);

  // Mismatch persists until a control access refreshes the copy
  assign mismatch = (res_sync != latched_res_ff);

  always @* begin
    rdata = 32'h0000_0000;
    case (addr_ff)
      `DCC_ADDR_CTL: begin
        rdata[`DCC_CTL_RES2_BIT] = res2;
        rdata[`DCC_CTL_RES1_BIT] = res1;
        rdata[`DCC_CTL_CIS_BIT]  = cis_ff;
        rdata[`DCC_CTL_MODE_MSB:`DCC_CTL_MODE_LSB] = mode_ff;
      end
      `DCC_ADDR_FLAG: begin
        rdata[`DCC_FLAG_BIT] = comparator_change_flag_ff;
      end
      `DCC_ADDR_DIR: begin
        rdata[`DCC_DIR_MSB:0] = dir_ff;
      end
      `DCC_ADDR_STAT: begin
        rdata[`DCC_STAT_SETTLE] = result_settling_ff;
      end
      default: begin
        rdata = 32'h0000_0000;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always @* begin
    nxt_mode = mode_ff;
    nxt_cis  = cis_ff;
    if (ctl_wr) begin
      nxt_mode = hwdata[`DCC_CTL_MODE_MSB:`DCC_CTL_MODE_LSB];
      nxt_cis  = hwdata[`DCC_CTL_CIS_BIT];
    end
    nxt_cfg = mode_cfg(nxt_mode, nxt_cis);
    // Set wins over a clearing write in the same cycle
    nxt_flag = comparator_change_flag_ff;
    if (flag_wr) begin
      nxt_flag = hwdata[`DCC_FLAG_BIT];
    end
    if (mismatch) begin
      nxt_flag = 1'b1;
    end
    // Settling restarts on every mode change, tracks the pending window
    // A same-mode write leaves a running count alone
    nxt_settle_cnt = settle_cnt_ff;
    if (ctl_wr && (nxt_mode != mode_ff)) begin
      nxt_settle_cnt = SETTLE_LOAD;
    end else if (settle_cnt_ff != {`DCC_SETTLE_W{1'b0}}) begin
      nxt_settle_cnt = settle_cnt_ff - {{(`DCC_SETTLE_W-1){1'b0}}, 1'b1};
    end
  end

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_pend_ff   <= 1'b0;
      rd_pend_ff   <= 1'b0;
      addr_ff      <= {`DCC_ADDR_W{1'b0}};
      hrdata_ff    <= 32'h0000_0000;
      hreadyout_ff <= 1'b1;
      hresp_ff     <= `DCC_HRESP_OKAY;
    end else if (ce) begin
      // Never an error: unmapped reads return zero
      hresp_ff   <= `DCC_HRESP_OKAY;
      wr_pend_ff <= ap_take & hwrite;
      rd_pend_ff <= ap_take & ~hwrite;
      if (ap_take) begin
        addr_ff <= {haddr[`DCC_ADDR_W-1:2], 2'h0};
      end
      if (ap_take && !hwrite) begin
        hreadyout_ff <= 1'b0;
      end else begin
        hreadyout_ff <= 1'b1;
      end
      if (rd_pend_ff) begin
        hrdata_ff <= rdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers and outputs
  // ----------------------------------------------------------------
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mode_ff                   <= `DCC_MODE_RST;
      cis_ff                    <= `DCC_CIS_RST;
      dir_ff                    <= `DCC_DIR_RST;
      latched_res_ff            <= 2'h0;
      settle_cnt_ff             <= {`DCC_SETTLE_W{1'b0}};
      comparator_change_flag_ff <= 1'b0;
      result_settling_ff        <= 1'b0;
      cmp_power_en_ff           <= 2'h0;
      cmp_pos_vref_ff           <= 1'b0;
      cmp1_pos_sel_ff           <= `DCC_PIN_RA0;
      cmp1_neg_sel_ff           <= `DCC_PIN_RA0;
      cmp2_pos_sel_ff           <= `DCC_PIN_RA0;
      cmp2_neg_sel_ff           <= `DCC_PIN_RA0;
      pa_analog_en_ff           <= 4'hF;
      ra3_ra4_cmp_route_ff      <= 1'b0;
      pa_oe_ff                  <= 5'h00;
    end else if (ce) begin
      mode_ff <= nxt_mode;
      cis_ff  <= nxt_cis;
      if (wr_pend_ff && (addr_ff == `DCC_ADDR_DIR)) begin
        dir_ff <= hwdata[`DCC_DIR_MSB:0];
      end
      // Snapshot matches what a control read returns this cycle
      if (ctl_wr || ctl_rd) begin
        latched_res_ff <= res_sync;
      end
      settle_cnt_ff             <= nxt_settle_cnt;
      result_settling_ff        <= (nxt_settle_cnt != {`DCC_SETTLE_W{1'b0}});
      comparator_change_flag_ff <= nxt_flag;
      {cmp_power_en_ff, cmp_pos_vref_ff, cmp1_pos_sel_ff, cmp1_neg_sel_ff,
       cmp2_pos_sel_ff, cmp2_neg_sel_ff, pa_analog_en_ff,
       ra3_ra4_cmp_route_ff} <= nxt_cfg;
      // Direction bit 1 means input; holds in every mode
      // A direction write drives the enables without a cycle of lag
      if (wr_pend_ff && (addr_ff == `DCC_ADDR_DIR)) begin
        pa_oe_ff <= ~hwdata[`DCC_DIR_MSB:0];
      end else begin
        pa_oe_ff <= ~dir_ff;
      end
    end
  end

endmodule

// ---- dv/dcc_top_chk.sv ----
// Assertion checker bound to the dual comparator control top
`timescale 1ns/1ps
`include "dcc_consts.vh"
module dcc_top_chk #(
  parameter SETTLE_NS = `DCC_SETTLE_NS,
  parameter CLK_NS    = `DCC_CLK_NS
) (
  // Clock and reset
  input wire        clk,
  input wire        nrst,
  input wire        ce,
  // Bus
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire        hready,
  input wire [31:0] hwdata,
  input wire [31:0] hrdata_ff,
  input wire        hreadyout_ff,
  // Block outputs
  input wire [1:0]  cmp_power_en_ff,
  input wire        cmp_pos_vref_ff,
  input wire [3:0]  pa_analog_en_ff,
  input wire        ra3_ra4_cmp_route_ff,
  input wire [4:0]  pa_oe_ff,
  input wire        comparator_change_flag_ff,
  input wire        result_settling_ff
);
  // ----
  // Write tracking
  // ----
  wire        take = hsel && hready && htrans == `DCC_HTRANS_NONSEQ && ce;
  reg         wr_q_ff;
  reg  [11:0] adr_q_ff;
  reg  [2:0]  mode_q_ff;
  wire        wr_ctl = wr_q_ff && adr_q_ff == `DCC_IDX_CTL;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_q_ff   <= 1'b0;
      adr_q_ff  <= 12'h000;
      mode_q_ff <= 3'h0;
    end else begin
      wr_q_ff  <= take && hwrite;
      adr_q_ff <= haddr[13:2];
      if (wr_ctl) mode_q_ff <= hwdata[2:0];
    end
  end
  // ----
  // Properties
  // ----
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  rd_wait_a: assert property (take && !hwrite |=> !hreadyout_ff ##1 hreadyout_ff)
    else $error("read wait state wrong");
  wr_nowait_a: assert property (take && hwrite |=> hreadyout_ff)
    else $error("write stalled");
  rsv_zero_a: assert property (take && !hwrite && haddr[13:2] == `DCC_IDX_CTL
    |-> ##2 hrdata_ff[5:4] == 2'h0 && hrdata_ff[31:8] == 24'h0)
    else $error("reserved control bits not zero");
  route_m6_a: assert property (wr_ctl
    |=> ra3_ra4_cmp_route_ff == ($past(hwdata[2:0]) == 3'h6))
    else $error("pin route not tied to mode 6");
  vref_pw_a: assert property (cmp_pos_vref_ff
    |-> cmp_power_en_ff == 2'h3 && pa_analog_en_ff == 4'hF)
    else $error("reference selected outside its mode");
  dir_oe_a: assert property (wr_q_ff && adr_q_ff == `DCC_IDX_DIR
    |=> pa_oe_ff == ~$past(hwdata[4:0]))
    else $error("output enable not from direction");
  flag_set_a: assert property (wr_q_ff && adr_q_ff == `DCC_IDX_FLAG && hwdata[6]
    |=> comparator_change_flag_ff)
    else $error("written one did not set flag");
  settle_a: assert property (wr_ctl && hwdata[2:0] != mode_q_ff |=> result_settling_ff)
    else $error("mode change did not start settling");
  rst_val_a: assert property (!$past(nrst) |-> pa_analog_en_ff == 4'hF &&
    pa_oe_ff == 5'h00 && cmp_power_en_ff == 2'h0 && !comparator_change_flag_ff)
    else $error("reset state wrong");
endmodule
bind dcc_top dcc_top_chk #(.SETTLE_NS(SETTLE_NS), .CLK_NS(CLK_NS)) u_chk (
  .clk(clk), .nrst(nrst), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .hrdata_ff(hrdata_ff),
  .hreadyout_ff(hreadyout_ff), .cmp_power_en_ff(cmp_power_en_ff),
  .cmp_pos_vref_ff(cmp_pos_vref_ff), .pa_analog_en_ff(pa_analog_en_ff),
  .ra3_ra4_cmp_route_ff(ra3_ra4_cmp_route_ff), .pa_oe_ff(pa_oe_ff),
  .comparator_change_flag_ff(comparator_change_flag_ff),
  .result_settling_ff(result_settling_ff));

// ---- dv/dcc_analog_model.sv ----
// Behavioural comparators fed from pin levels and the internal reference
`timescale 1ns/1ps
module dcc_analog_model #(
  parameter VREF_LVL = 8'h80
) (
  // Mux controls
  input  wire [1:0]  power_en,
  input  wire        vref_sel,
  input  wire [1:0]  c1p,
  input  wire [1:0]  c1n,
  input  wire [1:0]  c2p,
  input  wire [1:0]  c2n,
  // Pin levels RA3..RA0, one byte each
  input  wire [31:0] pins,
  // Raw results
  output wire        cmp1_raw,
  output wire        cmp2_raw
);
  // Powered-down comparator reads low
  assign cmp1_raw = power_en[0] &&
    ((vref_sel ? VREF_LVL : pins[{c1p, 3'h0} +: 8]) > pins[{c1n, 3'h0} +: 8]);
  assign cmp2_raw = power_en[1] &&
    ((vref_sel ? VREF_LVL : pins[{c2p, 3'h0} +: 8]) > pins[{c2n, 3'h0} +: 8]);
endmodule

// ---- dv/dual_comparator_control_test.sv ----
// Self-checking bench for the dual comparator control block
`timescale 1ns/1ps
`include "dcc_consts.vh"
module dual_comparator_control_test;
  // ----
  // Signals
  // ----
  logic        clk = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, pins = 32'h0, rd;
  wire  [31:0] hrdata_ff;
  wire         hreadyout_ff, c1r, c2r, route, flag, settling, vref_sel, hresp;
  wire  [1:0]  pwr, c1p, c1n, c2p, c2n;
  wire  [3:0]  ana;
  wire  [4:0]  oe;
  int          fail_count = 0, num_checks = 0;
  // Power, reference, analog enables, route for each mode
  logic [7:0]  cfg_tab [0:7] = '{8'h1E, 8'hDE, 8'hFE, 8'hCE, 8'hDE, 8'h8C, 8'hCF, 8'h00};
  dcc_top #(.SETTLE_NS(50), .CLK_NS(10)) dut (.clk(clk), .nrst(nrst), .ce(1'b1),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hready(hreadyout_ff), .hwdata(hwdata), .hrdata_ff(hrdata_ff),
    .hreadyout_ff(hreadyout_ff), .hresp_ff(hresp), .cmp1_raw(c1r), .cmp2_raw(c2r),
    .cmp_power_en_ff(pwr), .cmp_pos_vref_ff(vref_sel), .cmp1_pos_sel_ff(c1p),
    .cmp1_neg_sel_ff(c1n), .cmp2_pos_sel_ff(c2p), .cmp2_neg_sel_ff(c2n),
    .pa_analog_en_ff(ana), .ra3_ra4_cmp_route_ff(route), .pa_oe_ff(oe),
    .comparator_change_flag_ff(flag), .result_settling_ff(settling));
  dcc_analog_model u_ana (.power_en(pwr), .vref_sel(vref_sel), .c1p(c1p), .c1n(c1n),
    .c2p(c2p), .c2n(c2n), .pins(pins), .cmp1_raw(c1r), .cmp2_raw(c2r));
  // ----
  // Shared tasks
  // ----
  task bus(input logic w, input logic [13:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= `DCC_HTRANS_NONSEQ;
    haddr <= {18'h0, a};
    hwrite <= w;
    @(posedge clk);
    while (hreadyout_ff !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout_ff !== 1'b1) @(posedge clk);
    rd = hrdata_ff;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Sync path needs a few cycles after settling ends
  task settle;
    for (int n = 0; n < 50 && settling !== 1'b0; n++) @(posedge clk);
    repeat (8) @(posedge clk);
  endtask
  task results;
    if (fail_count == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ----
  // Scenarios
  // ----
  task t_reset;
    bus(1'b0, `DCC_ADDR_CTL, 32'h0);
    chk("control", 32'h0, rd);
    bus(1'b0, `DCC_ADDR_DIR, 32'h0);
    chk("direction", 32'h1F, rd);
    chk("analog", 32'hF, 32'(ana));
  endtask
  task t_modes;
    for (int m = 0; m < 16; m++) begin
      bus(1'b1, `DCC_ADDR_CTL, {28'h0, m[3:0]});
      #1;
      chk("config", 32'(cfg_tab[m[2:0]]), 32'({pwr, vref_sel, ana, route}));
      if (m[2:0] == 3'h1 || m[2:0] == 3'h2)
        chk("neg", {28'h0, m[3] ? 2'h3 : 2'h0, (m[2:0] == 3'h2 && m[3]) ? 2'h2 : 2'h1},
          32'({c1n, c2n}));
      if (m[2:0] == 3'h3 || m[2:0] == 3'h4)
        chk("plus", {28'h0, m[2] ? 2'h3 : 2'h2, 2'h2}, 32'({c1p, c2p}));
    end
    bus(1'b1, `DCC_ADDR_CTL, 32'hFF);
    settle;
    bus(1'b0, `DCC_ADDR_CTL, 32'h0);
    chk("control", 32'h0F, rd);
  endtask
  task t_dir;
    bus(1'b1, `DCC_ADDR_DIR, 32'h07);
    #1;
    chk("oe", 32'h18, 32'(oe));
    bus(1'b1, `DCC_ADDR_CTL, 32'h06);
    #1;
    chk("oe mode6", 32'h18, 32'(oe));
    bus(1'b1, 14'h0040, 32'hFF);
    bus(1'b0, 14'h0040, 32'h0);
    chk("unmapped", 32'h0, rd);
    chk("response", 32'h0, 32'(hresp));
  endtask
  task t_flag;
    @(posedge clk);
    pins <= 32'hC8326464;
    bus(1'b1, `DCC_ADDR_CTL, 32'h04);
    #1;
    chk("settling", 32'h1, 32'(settling));
    bus(1'b0, `DCC_ADDR_STAT, 32'h0);
    chk("status", 32'h1, rd);
    settle;
    bus(1'b0, `DCC_ADDR_STAT, 32'h0);
    chk("status", 32'h0, rd);
    bus(1'b0, `DCC_ADDR_CTL, 32'h0);
    chk("results", 32'h44, rd);
    bus(1'b1, `DCC_ADDR_FLAG, 32'h0);
    #1;
    chk("flag", 32'h0, 32'(flag));
    @(posedge clk);
    pins <= 32'hC8966464;
    repeat (8) @(posedge clk);
    chk("flag", 32'h1, 32'(flag));
    bus(1'b1, `DCC_ADDR_FLAG, 32'h0);
    #1;
    chk("flag held", 32'h1, 32'(flag));
    bus(1'b0, `DCC_ADDR_CTL, 32'h0);
    chk("results", 32'hC4, rd);
    bus(1'b1, `DCC_ADDR_FLAG, 32'h0);
    bus(1'b0, `DCC_ADDR_FLAG, 32'h0);
    chk("flag reg", 32'h0, rd);
    bus(1'b1, `DCC_ADDR_FLAG, 32'h40);
    bus(1'b0, `DCC_ADDR_FLAG, 32'h0);
    chk("flag reg", 32'h40, rd);
  endtask
  task t_rst;
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    bus(1'b0, `DCC_ADDR_CTL, 32'h0);
    chk("control", 32'h0, rd);
    chk("oe", 32'h0, 32'(oe));
  endtask
  // ----
  // Run
  // ----
  initial begin
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    t_reset;
    t_modes;
    t_dir;
    t_flag;
    t_rst;
    results;
  end
  // Whole run is well under a thousand cycles
  initial begin
    #100000;
    fail_count++;
    results;
  end
endmodule
